// ### verilog/rbu_pkg.sv
// Constants and state types shared by the relative branch unit
`default_nettype none

package rbu_pkg;

	////////////////////////////////////////////////////////////////////
	// Widths
	localparam int PC_WIDTH = 24;
	localparam int WORD_WIDTH = 24;
	localparam int REG_WIDTH = 16;
	localparam int REG_COUNT = 16;
	localparam int SEL_WIDTH = 4;
	localparam int FLAG_COUNT = 4;

	////////////////////////////////////////////////////////////////////
	// Instruction word fields
	localparam int OPC_BYTE_MSB = 23;
	localparam int OPC_BYTE_LSB = 16;
	localparam int PREFIX_MSB = 23;
	localparam int PREFIX_LSB = 4;
	localparam int SEL_MSB = 3;
	localparam int SEL_LSB = 0;
	localparam int LIT_MSB = 15;
	localparam int LIT_LSB = 0;

	////////////////////////////////////////////////////////////////////
	// Opcodes
	localparam logic [19:0] OPC_COMPUTED_PREFIX = 20'h01600;
	localparam logic [7:0] OPC_CARRY = 8'h31;
	localparam logic [7:0] OPC_SIGNED_GE = 8'h3D;
	localparam logic [7:0] OPC_SIGNED_GT = 8'h3C;
	localparam logic [7:0] OPC_UNSIGNED_GT = 8'h3F;
	localparam logic [7:0] OPC_UNSIGNED_LE = 8'h36;

	////////////////////////////////////////////////////////////////////
	// Arithmetic and reset values
	localparam logic [PC_WIDTH-1:0] PC_STEP = 24'h000002;
	localparam logic [PC_WIDTH-1:0] PC_RESET = 24'h000000;
	localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 4'h0;
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_OV = 3;

	////////////////////////////////////////////////////////////////////
	// Control state
	typedef enum logic [0:0] {
		RBU_IDLE,
		RBU_FILL
	} rbu_state_type;

	typedef struct packed {
		rbu_state_type state;
		logic ready;
		logic pcLoad;
		logic [PC_WIDTH-1:0] pcTarget;
		logic taken;
		logic filler;
		logic done;
		logic unknown;
		logic [FLAG_COUNT-1:0] flags;
	} rbu_regs_type;

endpackage : rbu_pkg

`default_nettype wire

// ### verilog/rbu_cond_eval.sv
// Condition decoder for the conditional relative branches
`default_nettype none

module rbu_cond_eval
	import rbu_pkg::*;
(
	// Opcode byte
	input wire logic [7:0] opcodeByte,
	// Status flags
	input wire logic carryFlag,
	input wire logic zeroFlag,
	input wire logic negativeFlag,
	input wire logic overflowFlag,
	// Decode result
	output logic isCond,
	output logic condTrue
);

	////////////////////////////////////////////////////////////////////
	// Flags are only read here, never written back
	always_comb
	begin
		isCond = 1'b1;
		condTrue = 1'b0;
		if (opcodeByte == OPC_CARRY)
		begin
			condTrue = carryFlag;
		end
		else if (opcodeByte == OPC_SIGNED_GE)
		begin
			condTrue = ~(negativeFlag ^ overflowFlag);
		end
		else if (opcodeByte == OPC_SIGNED_GT)
		begin
			condTrue = ~zeroFlag & ~(negativeFlag ^ overflowFlag);
		end
		else if (opcodeByte == OPC_UNSIGNED_GT)
		begin
			condTrue = carryFlag & ~zeroFlag;
		end
		else if (opcodeByte == OPC_UNSIGNED_LE)
		begin
			condTrue = ~carryFlag | zeroFlag;
		end
		else
		begin
			isCond = 1'b0;
		end
	end

endmodule : rbu_cond_eval

`default_nettype wire

// ### verilog/rbu_target_calc.sv
// Branch target adder: next PC plus a doubled signed word offset
`default_nettype none

module rbu_target_calc
	import rbu_pkg::*;
(
	// Operands
	input wire logic [PC_WIDTH-1:0] pcValue,
	input wire logic [REG_WIDTH-1:0] offsetWords,
	// Result
	output logic [PC_WIDTH-1:0] target
);

	logic [PC_WIDTH-1:0] byteOffset;

	////////////////////////////////////////////////////////////////////
	// Doubling gives a 17-bit value, sign-extended to PC width;
	// the sum wraps at the PC width like the program counter does
	always_comb
	begin
		byteOffset = {{(PC_WIDTH-REG_WIDTH-1){offsetWords[REG_WIDTH-1]}},
			offsetWords, 1'b0};
		target = pcValue + PC_STEP + byteOffset;
	end

endmodule : rbu_target_calc

`default_nettype wire

// ### verilog/rbu_branch_unit.sv
// Relative branch unit: decode, condition test and PC load sequencing
`default_nettype none

module rbu_branch_unit
	import rbu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction in
	input wire logic instrValid,
	input wire logic [WORD_WIDTH-1:0] instrWord,
	input wire logic [PC_WIDTH-1:0] pcValue,
	output logic instrReady,
	// Working register file, register n at bits 16n+15..16n
	input wire logic [REG_COUNT*REG_WIDTH-1:0] workingRegs,
	// Status flags
	input wire logic carryFlag,
	input wire logic zeroFlag,
	input wire logic negativeFlag,
	input wire logic overflowFlag,
	// Program counter control
	output logic pcLoad,
	output logic [PC_WIDTH-1:0] pcTarget,
	output logic branchTaken,
	output logic idleFillerOp,
	// Completion and status
	output logic instrDone,
	output logic instrUnknown,
	output logic [FLAG_COUNT-1:0] flagsOut
);

	////////////////////////////////////////////////////////////////////
	// State and decode nets
	rbu_regs_type regs;
	rbu_regs_type next_regs;

	logic accept;
	logic isComputed;
	logic isCond;
	logic condTrue;
	logic takeBranch;
	logic [7:0] opcodeByte;
	logic [SEL_WIDTH-1:0] regSelect;
	logic [REG_WIDTH-1:0] selectedReg;
	logic [REG_WIDTH-1:0] offsetWords;
	logic [PC_WIDTH-1:0] targetValue;

	////////////////////////////////////////////////////////////////////
	// Field extraction
	assign opcodeByte = instrWord[OPC_BYTE_MSB:OPC_BYTE_LSB];
	assign regSelect = instrWord[SEL_MSB:SEL_LSB];

	// Full 20-bit prefix match, so stray bits do not alias
	assign isComputed =
		(instrWord[PREFIX_MSB:PREFIX_LSB] == OPC_COMPUTED_PREFIX);

	// Word-wide part select into the flattened register file
	assign selectedReg = workingRegs[{regSelect, 4'h0} +: REG_WIDTH];

	// Register offset for computed, literal for conditional
	assign offsetWords = isComputed ? selectedReg :
		instrWord[LIT_MSB:LIT_LSB];

	////////////////////////////////////////////////////////////////////
	// Condition decoder
	rbu_cond_eval rbu_cond_eval_i (
		.opcodeByte(opcodeByte),
		.carryFlag(carryFlag),
		.zeroFlag(zeroFlag),
		.negativeFlag(negativeFlag),
		.overflowFlag(overflowFlag),
		.isCond(isCond),
		.condTrue(condTrue)
	);

	////////////////////////////////////////////////////////////////////
	// Target adder
	rbu_target_calc rbu_target_calc_i (
		.pcValue(pcValue),
		.offsetWords(offsetWords),
		.target(targetValue)
	);

	////////////////////////////////////////////////////////////////////
	// Handshake and take decision
	assign accept = instrValid & regs.ready;

	// Computed branch has no condition: always taken
	assign takeBranch = isComputed | (isCond & condTrue);

	////////////////////////////////////////////////////////////////////
	// Next-state logic; pulses default low every cycle
	always_comb
	begin
		next_regs = regs;
		next_regs.pcLoad = 1'b0;
		next_regs.done = 1'b0;
		next_regs.unknown = 1'b0;
		next_regs.filler = 1'b0;
		case (regs.state)
			RBU_IDLE:
			begin
				if (accept)
				begin
					// Flags pass through untouched
					next_regs.flags = {overflowFlag, negativeFlag,
						zeroFlag, carryFlag};
					next_regs.taken = takeBranch;
					if (takeBranch)
					begin
						// Load target and raise filler together, done next cycle
						next_regs.pcLoad = 1'b1;
						next_regs.pcTarget = targetValue;
						next_regs.filler = 1'b1;
						next_regs.ready = 1'b0;
						next_regs.state = RBU_FILL;
					end
					else if (isCond)
					begin
						// Not taken: done in a single cycle
						next_regs.done = 1'b1;
					end
					else
					begin
						// Not one of ours; no PC change
						next_regs.done = 1'b1;
						next_regs.unknown = 1'b1;
					end
				end
			end
			RBU_FILL:
			begin
				// Filler op occupies this second cycle
				next_regs.done = 1'b1;
				next_regs.ready = 1'b1;
				next_regs.state = RBU_IDLE;
			end
			default:
			begin
				next_regs.ready = 1'b1;
				next_regs.state = RBU_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// State register; synchronous reset
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			regs.state <= RBU_IDLE;
			regs.ready <= 1'b1;
			regs.pcLoad <= 1'b0;
			regs.pcTarget <= PC_RESET;
			regs.taken <= 1'b0;
			regs.filler <= 1'b0;
			regs.done <= 1'b0;
			regs.unknown <= 1'b0;
			regs.flags <= FLAGS_RESET;
		end
		else
		begin
			regs <= next_regs;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs straight from the state flops
	assign instrReady = regs.ready;
	assign pcLoad = regs.pcLoad;
	assign pcTarget = regs.pcTarget;
	assign branchTaken = regs.taken;
	assign idleFillerOp = regs.filler;
	assign instrDone = regs.done;
	assign instrUnknown = regs.unknown;
	assign flagsOut = regs.flags;

endmodule : rbu_branch_unit

`default_nettype wire

// ### dv/rbu_branch_checker.sv
// Port-level checks for the relative branch unit
`default_nettype none

module rbu_branch_checker
	import rbu_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction side
	input wire logic instrValid,
	input wire logic [WORD_WIDTH-1:0] instrWord,
	input wire logic instrReady,
	// Flags
	input wire logic carryFlag,
	input wire logic zeroFlag,
	input wire logic negativeFlag,
	input wire logic overflowFlag,
	// Results
	input wire logic pcLoad,
	input wire logic branchTaken,
	input wire logic idleFillerOp,
	input wire logic instrDone,
	input wire logic [FLAG_COUNT-1:0] flagsOut
);

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Accept strobe and condition terms seen at the accept edge
	wire acc = instrValid && instrReady;
	wire [7:0] op = instrWord[OPC_BYTE_MSB:OPC_BYTE_LSB];
	wire nv = negativeFlag == overflowFlag;
	wire [3:0] fl = {overflowFlag, negativeFlag, zeroFlag, carryFlag};

	////////////////////////////////////////////////////////////////////
	// Decision of each conditional branch, one cycle after accept
	carry_cond_a: assert property (acc && op == OPC_CARRY
		|=> branchTaken == $past(carryFlag)) else $error("carry decision");
	signed_ge_a: assert property (acc && op == OPC_SIGNED_GE
		|=> branchTaken == $past(nv)) else $error("signed ge decision");
	signed_gt_a: assert property (acc && op == OPC_SIGNED_GT
		|=> branchTaken == $past(nv && !zeroFlag)) else $error("signed gt");
	unsigned_gt_a: assert property (acc && op == OPC_UNSIGNED_GT
		|=> branchTaken == $past(carryFlag && !zeroFlag)) else $error("gtu");
	unsigned_le_a: assert property (acc && op == OPC_UNSIGNED_LE
		|=> branchTaken == $past(!carryFlag || zeroFlag)) else $error("leu");

	////////////////////////////////////////////////////////////////////
	// Sequencing: computed always loads, taken is two cycles, else one
	computed_load_a: assert property (acc
		&& instrWord[PREFIX_MSB:PREFIX_LSB] == OPC_COMPUTED_PREFIX
		|=> pcLoad && branchTaken) else $error("computed branch not taken");
	taken_fill_a: assert property (pcLoad |-> idleFillerOp
		&& !instrReady && !instrDone ##1 instrDone && instrReady)
		else $error("taken branch sequence");
	single_done_a: assert property (acc
		|=> branchTaken != instrDone) else $error("completion timing");

	// Flags only follow the accepted sample and are never altered
	flags_held_a: assert property (1'h1
		|=> flagsOut == $past(acc ? fl : flagsOut)) else $error("flags moved");

endmodule : rbu_branch_checker

`default_nettype wire

// ### dv/rbu_branch_unit_bench.sv
// Directed testbench for the relative branch unit
`default_nettype none

module rbu_branch_unit_bench
	import rbu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk = 1'h0, rst = 1'h1, instrValid = 1'h0;
	logic [23:0] instrWord = '0, pcValue = '0, pcTarget;
	logic [255:0] workingRegs = '0;
	logic carryFlag = 1'h0, zeroFlag = 1'h0;
	logic negativeFlag = 1'h0, overflowFlag = 1'h0;
	logic instrReady, pcLoad, branchTaken, idleFillerOp;
	logic instrDone, instrUnknown;
	logic [3:0] flagsOut;
	int errors = 0, checks_done = 0;
	localparam logic [7:0] OPS [5] = '{OPC_CARRY, OPC_SIGNED_GE,
		OPC_SIGNED_GT, OPC_UNSIGNED_GT, OPC_UNSIGNED_LE};

	// Unit under test
	rbu_branch_unit rbu_branch_unit_i (.clk, .rst, .instrValid, .instrWord,
		.pcValue, .instrReady, .workingRegs, .carryFlag, .zeroFlag,
		.negativeFlag, .overflowFlag, .pcLoad, .pcTarget, .branchTaken,
		.idleFillerOp, .instrDone, .instrUnknown, .flagsOut);

	// Clock, 40 ns period
	initial forever #20 clk = ~clk;

	////////////////////////////////////////////////////////////////////
	// Compare, count and report
	task chk(input logic [23:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// Expected decision of a conditional opcode, flags as {OV,N,Z,C}
	function automatic logic cond(input logic [7:0] o, input logic [3:0] f);
		case (o)
			OPC_CARRY: return f[0];
			OPC_SIGNED_GE: return f[2] == f[3];
			OPC_SIGNED_GT: return !f[1] && f[2] == f[3];
			OPC_UNSIGNED_GT: return f[0] && !f[1];
			default: return !f[0] || f[1];
		endcase
	endfunction : cond

	// Next PC plus the doubled, sign-extended word offset, wrapping
	function automatic logic [23:0] tgt(input logic [23:0] p, w);
		return p + 24'h000002 + {w[15] ? 7'h7F : 7'h00, w[15:0], 1'h0};
	endfunction : tgt

	// Present one word and judge the answer; valid is left high so that
	// not-taken words run back to back and the ready-low slot is probed
	task issue(input logic [23:0] w, p, input logic [3:0] f,
		input logic tk, unk, input logic [23:0] tg);
		instrWord = w;
		pcValue = p;
		{overflowFlag, negativeFlag, zeroFlag, carryFlag} = f;
		instrValid = 1'h1;
		@(posedge clk) #1;
		chk(branchTaken, tk);
		chk(flagsOut, f);
		chk(instrUnknown, unk);
		chk(pcLoad, tk);
		chk(idleFillerOp, tk);
		chk(instrDone, !tk);
		chk(instrReady, !tk);
		if (tk)
		begin
			chk(pcTarget, tg);
			instrWord = 24'h000000;
			@(posedge clk) #1;
			chk(instrDone, 1'h1);
			chk(instrUnknown, 1'h0);
			chk(instrReady, 1'h1);
		end
	endtask : issue

	////////////////////////////////////////////////////////////////////
	// Each condition against all flag patterns, extreme offsets, PC wrap
	task cond_sweep;
		logic [23:0] w, p;
		for (int i = 0; i < 5; i++)
			for (int f = 0; f < 16; f++)
			begin
				w = {OPS[i], f[0] ? 16'h7FFF : 16'h8000};
				p = {f[3:0], 20'hFFFFE};
				issue(w, p, f[3:0], cond(OPS[i], f[3:0]), 1'h0, tgt(p, w));
			end
		instrValid = 1'h0;
	endtask : cond_sweep

	// Computed branch through every working register, some negative
	task computed_sweep;
		logic [255:0] r;
		for (int s = 0; s < 16; s++)
			r[s*16 +: 16] = 16'h1111 * s[15:0];
		workingRegs = r;
		for (int s = 0; s < 16; s++)
			issue({OPC_COMPUTED_PREFIX, s[3:0]}, 24'h002000, s[3:0], 1'h1,
				1'h0, tgt(24'h002000, {8'h00, r[s*16 +: 16]}));
		instrValid = 1'h0;
	endtask : computed_sweep

	// Near-miss and foreign words complete at once with no load
	task unknown_words;
		issue(24'h016010, 24'h000100, 4'hF, 1'h0, 1'h1, '0);
		issue(24'h390000, 24'h000100, 4'h0, 1'h0, 1'h1, '0);
		issue(24'h000000, 24'h000100, 4'h5, 1'h0, 1'h1, '0);
		instrValid = 1'h0;
	endtask : unknown_words

	// Verdict and end of run
	task results;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	// Reset for three cycles, then the scenarios
	initial
	begin
		repeat (3) @(posedge clk);
		#1 rst = 1'h0;
		@(posedge clk) #1;
		cond_sweep;
		computed_sweep;
		unknown_words;
		@(posedge clk) #1;
		results;
	end

endmodule : rbu_branch_unit_bench

bind rbu_branch_unit rbu_branch_checker rbu_branch_checker_i (.clk, .rst,
	.instrValid, .instrWord, .instrReady, .carryFlag, .zeroFlag,
	.negativeFlag, .overflowFlag, .pcLoad, .branchTaken, .idleFillerOp,
	.instrDone, .flagsOut);

`default_nettype wire
